// >>> common/dsp_port_pkg.sv
// Purpose: Shared constants for the DSP host port bridge.
// Assumes: One 25 MHz clock for both ends.
// Notes:   Times are in ns; cycle counts derive from them.

package dsp_port_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_NS     = 40;
   localparam int STROBE_NS  = 50;
   localparam int RECOVER_NS = 50;
   localparam int ACCESS_NS  = 100;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] STROBE_LAST  = CNT_W'(STROBE_CYC - 1);
   localparam logic [CNT_W-1:0] RECOVER_LAST = CNT_W'(RECOVER_CYC - 1);

   // -------------------------------------------------------------
   // Port geometry
   // -------------------------------------------------------------
   localparam int NUM_REGS = 16;
   localparam int IDX_W    = 4;
   localparam int ADDR_W   = 5;
   localparam int BUS_W    = 16;
   localparam int REG_W    = 8;
   localparam int IDX_LSB  = 1;

   // -------------------------------------------------------------
   // Soft reset register, on the system bank at index 0
   // -------------------------------------------------------------
   localparam int NUM_SRST = 4;
   localparam int VOUT_BIT = 0;
   localparam int FIFO_BIT = 1;
   localparam int VIN_BIT  = 2;
   localparam int DSP_BIT  = 3;
   localparam logic [IDX_W-1:0]    SRST_IDX  = 4'h0;
   localparam logic [NUM_SRST-1:0] SRST_INIT = 4'h0;

   // -------------------------------------------------------------
   // Host controller Avalon map (word index)
   // -------------------------------------------------------------
   localparam int AV_W = 3;
   localparam logic [AV_W-1:0] A_CTRL     = 3'h0;
   localparam logic [AV_W-1:0] A_WDATA    = 3'h1;
   localparam logic [AV_W-1:0] A_RDATA    = 3'h2;
   localparam logic [AV_W-1:0] A_STATUS   = 3'h3;
   localparam logic [AV_W-1:0] A_IRQ_STAT = 3'h4;
   localparam logic [AV_W-1:0] A_IRQ_CLR  = 3'h5;
   localparam logic [AV_W-1:0] A_IRQ_EN   = 3'h6;
   localparam int GO_BIT   = 0;
   localparam int RD_BIT   = 1;
   localparam int SYS_BIT  = 2;
   localparam int CIDX_LSB = 4;
   localparam int NUM_IRQ  = 2;
   localparam int IRQ_DSP  = 0;
   localparam int IRQ_DONE = 1;

endpackage : dsp_port_pkg

// >>> common/dsp_port_if.sv
// Purpose: Parallel bus between host controller and DSP port.
// Assumes: Both ends run on the same clock.
// Notes:   Strobes and selects are active low; data is shared.

`timescale 1ns/1ps
`default_nettype none

interface dsp_port_if;

   // Selects, strobes and address from the host.
   logic                               cs_b;
   logic                               sys_cs_b;
   logic                               rd_b;
   logic                               wr_b;
   logic [dsp_port_pkg::ADDR_W-1:0]    addr;
   logic [dsp_port_pkg::BUS_W-1:0]     host_d;
   logic                               host_d_oe;
   // Read data and interrupt from the device.
   logic [dsp_port_pkg::BUS_W-1:0]     dev_d;
   logic                               dev_d_oe;
   logic                               irq;
   // Resolved shared data bus; undriven reads as zero.
   logic [dsp_port_pkg::BUS_W-1:0]     data;

   // The driver with its enable high owns the bus.
   assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : '0);

   modport host (
      output cs_b, sys_cs_b, rd_b, wr_b, addr, host_d, host_d_oe,
      input  data, irq
   );

   modport dev (
      input  cs_b, sys_cs_b, rd_b, wr_b, addr, data,
      output dev_d, dev_d_oe, irq
   );

endinterface : dsp_port_if

`default_nettype wire

// >>> logic/irq_block.sv
// Purpose: Sticky event status, enable mask and one level interrupt.
// Assumes: Events are one-cycle pulses.
// Notes:   A set in the clear cycle wins over the clear.

`timescale 1ns/1ps
`default_nettype none

module irq_block #(
   parameter int N = 2
) (
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // Events and register writes.
   input  wire logic [N-1:0] event_i,
   input  wire logic         clr_wr_i,
   input  wire logic         en_wr_i,
   input  wire logic [N-1:0] wdata_i,
   // Status, mask and interrupt.
   output logic      [N-1:0] stat_o,
   output logic      [N-1:0] en_o,
   output logic              irq_o
);

   // Sticky status: clear ones written, then add new events.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         stat_o <= '0;
      else
         stat_o <= (stat_o & ~(clr_wr_i ? wdata_i : '0)) | event_i;
   end

   // Enable mask.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         en_o <= '0;
      else if (en_wr_i)
         en_o <= wdata_i;
   end

   // Level output while any enabled bit is set.
   assign irq_o = |(stat_o & en_o);

endmodule : irq_block

`default_nettype wire

// >>> logic/dsp_host_ctrl.sv
// Purpose: Host end: turns Avalon register orders into port cycles.
// Assumes: Avalon-MM slave with waitrequest, word addresses.
// Notes:   Strobe and recovery are whole cycles of at least 50 ns.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module dsp_host_ctrl (
   // Clock and reset.
   input  wire logic                            CORE_CLK_I,
   input  wire logic                            RST_B_I,
   // Avalon-MM slave.
   input  wire logic [dsp_port_pkg::AV_W-1:0]   AVS_ADDRESS_I,
   input  wire logic                            AVS_READ_I,
   input  wire logic                            AVS_WRITE_I,
   input  wire logic [31:0]                     AVS_WRITEDATA_I,
   output logic      [31:0]                     AVS_READDATA_O,
   output logic                                 AVS_WAITREQUEST_O,
   // Interrupt to the processor.
   output logic                                 IRQ_O,
   // Port to the DSP.
   dsp_port_if.host                             PORT
);

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_STROBE  = 3'b010,
      ST_RECOVER = 3'b100
   } state_e;

   state_e                              state;
   logic [dsp_port_pkg::CNT_W-1:0]      cnt;
   logic [dsp_port_pkg::IDX_W-1:0]      idx;
   logic                                rd_op;
   logic                                sys_op;
   logic [dsp_port_pkg::REG_W-1:0]      wdata;
   logic [dsp_port_pkg::REG_W-1:0]      rdata;
   logic                                rd_valid;
   logic                                irq_prev;
   logic                                done;
   logic                                go;
   logic [dsp_port_pkg::NUM_IRQ-1:0]    stat;
   logic [dsp_port_pkg::NUM_IRQ-1:0]    en;
   logic [dsp_port_pkg::NUM_IRQ-1:0]    events;

   // A start order is taken only while idle; otherwise dropped.
   assign go = AVS_WRITE_I && (AVS_ADDRESS_I == dsp_port_pkg::A_CTRL)
             && AVS_WRITEDATA_I[dsp_port_pkg::GO_BIT]
             && (state == ST_IDLE);

   // Order and write data registers.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         idx    <= '0;
         rd_op  <= 1'b0;
         sys_op <= 1'b0;
         wdata  <= '0;
      end
      else
      begin
         if (go)
         begin
            idx    <= AVS_WRITEDATA_I[dsp_port_pkg::CIDX_LSB +:
                                      dsp_port_pkg::IDX_W];
            rd_op  <= AVS_WRITEDATA_I[dsp_port_pkg::RD_BIT];
            sys_op <= AVS_WRITEDATA_I[dsp_port_pkg::SYS_BIT];
         end
         if (AVS_WRITE_I && AVS_ADDRESS_I == dsp_port_pkg::A_WDATA)
            wdata <= AVS_WRITEDATA_I[dsp_port_pkg::REG_W-1:0];
      end
   end

   // Cycle sequencer: strobe, then recovery, then idle.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         state <= ST_IDLE;
         cnt   <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (go)
               begin
                  state <= ST_STROBE;
                  cnt   <= '0;
               end
            ST_STROBE:
               if (cnt == dsp_port_pkg::STROBE_LAST)
               begin
                  state <= ST_RECOVER;
                  cnt   <= '0;
               end
               else
                  cnt <= cnt + 1'b1;
            ST_RECOVER:
               if (cnt == dsp_port_pkg::RECOVER_LAST)
                  state <= ST_IDLE;
               else
                  cnt <= cnt + 1'b1;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   assign done = (state == ST_STROBE) && (cnt == dsp_port_pkg::STROBE_LAST);

   // Port pins; each bank has its own select.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         PORT.cs_b      <= 1'b1;
         PORT.sys_cs_b  <= 1'b1;
         PORT.rd_b      <= 1'b1;
         PORT.wr_b      <= 1'b1;
         PORT.addr      <= '0;
         PORT.host_d    <= '0;
         PORT.host_d_oe <= 1'b0;
      end
      else if (go)
      begin
         PORT.cs_b     <= AVS_WRITEDATA_I[dsp_port_pkg::SYS_BIT];
         PORT.sys_cs_b <= ~AVS_WRITEDATA_I[dsp_port_pkg::SYS_BIT];
         PORT.rd_b     <= ~AVS_WRITEDATA_I[dsp_port_pkg::RD_BIT];
         PORT.wr_b     <= AVS_WRITEDATA_I[dsp_port_pkg::RD_BIT];
         PORT.addr     <= {AVS_WRITEDATA_I[dsp_port_pkg::CIDX_LSB +:
                           dsp_port_pkg::IDX_W], 1'b0};
         PORT.host_d   <= {{(dsp_port_pkg::BUS_W -
                           dsp_port_pkg::REG_W){1'b0}}, wdata};
         PORT.host_d_oe <= ~AVS_WRITEDATA_I[dsp_port_pkg::RD_BIT];
      end
      else if (done)
      begin
         PORT.cs_b      <= 1'b1;
         PORT.sys_cs_b  <= 1'b1;
         PORT.rd_b      <= 1'b1;
         PORT.wr_b      <= 1'b1;
         PORT.host_d_oe <= 1'b0;
      end
   end

   // Read data is taken at the last strobe edge.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         rdata <= '0;
      else if (done && rd_op)
         rdata <= PORT.data[dsp_port_pkg::REG_W-1:0];
   end

   // Events: DSP line rising, and a finished cycle.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         irq_prev <= 1'b0;
      else
         irq_prev <= PORT.irq;
   end

   assign events[dsp_port_pkg::IRQ_DSP]  = PORT.irq & ~irq_prev;
   assign events[dsp_port_pkg::IRQ_DONE] = done;

   irq_block #(
      .N (dsp_port_pkg::NUM_IRQ)
   ) u_irq (
      .clk_i    (CORE_CLK_I),
      .rst_b_i  (RST_B_I),
      .event_i  (events),
      .clr_wr_i (AVS_WRITE_I && AVS_ADDRESS_I == dsp_port_pkg::A_IRQ_CLR),
      .en_wr_i  (AVS_WRITE_I && AVS_ADDRESS_I == dsp_port_pkg::A_IRQ_EN),
      .wdata_i  (AVS_WRITEDATA_I[dsp_port_pkg::NUM_IRQ-1:0]),
      .stat_o   (stat),
      .en_o     (en),
      .irq_o    (IRQ_O)
   );

   // Reads wait one cycle while the answer is registered.
   assign AVS_WAITREQUEST_O = AVS_READ_I & ~rd_valid;

   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         rd_valid       <= 1'b0;
         AVS_READDATA_O <= '0;
      end
      else
      begin
         rd_valid <= AVS_READ_I & ~rd_valid;
         case (AVS_ADDRESS_I)
            dsp_port_pkg::A_CTRL:
               AVS_READDATA_O <= {24'h0000_00, idx, 1'b0, sys_op,
                                  rd_op, 1'b0};
            dsp_port_pkg::A_WDATA:    AVS_READDATA_O <= {24'h0000_00, wdata};
            dsp_port_pkg::A_RDATA:    AVS_READDATA_O <= {24'h0000_00, rdata};
            dsp_port_pkg::A_STATUS:
               AVS_READDATA_O <= {31'h0000_0000, state != ST_IDLE};
            dsp_port_pkg::A_IRQ_STAT: AVS_READDATA_O <= {30'h0000_0000, stat};
            dsp_port_pkg::A_IRQ_EN:   AVS_READDATA_O <= {30'h0000_0000, en};
            default:                  AVS_READDATA_O <= '0;
         endcase
      end
   end

endmodule : dsp_host_ctrl

`default_nettype wire

// >>> logic/dsp_port_dev.sv
// Purpose: Device end: sixteen byte registers of the DSP port,
//          the soft reset register and the DSP interrupt line.
// Assumes: Port inputs are synchronous to CORE_CLK_I.
// Notes:   Writes take effect on the first strobe cycle.

`timescale 1ns/1ps
`default_nettype none

module dsp_port_dev #(
   parameter int NREGS = dsp_port_pkg::NUM_REGS
) (
   // Clock and reset.
   input  wire logic                              CORE_CLK_I,
   input  wire logic                              RST_B_I,
   // Bus from the host controller.
   dsp_port_if.dev                                PORT,
   // DSP core side: register updates and interrupt.
   input  wire logic                              CORE_WE_I,
   input  wire logic [dsp_port_pkg::IDX_W-1:0]    CORE_IDX_I,
   input  wire logic [dsp_port_pkg::REG_W-1:0]    CORE_DATA_I,
   input  wire logic                              CORE_IRQ_I,
   // DSP core side: host access notices.
   output logic                                   HOST_WR_O,
   output logic                                   HOST_RD_O,
   output logic      [dsp_port_pkg::IDX_W-1:0]    HOST_IDX_O,
   output logic      [dsp_port_pkg::REG_W-1:0]    HOST_DATA_O,
   // Subsystem soft resets, low holds in reset.
   output logic                                   DSP_CODEC_RST_B_O,
   output logic                                   VOUT_RST_B_O,
   output logic                                   VIN_RST_B_O,
   output logic                                   FIFO_RST_B_O
);

   // -------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------

   // Register index from the address, byte bit dropped.
   function automatic logic [dsp_port_pkg::IDX_W-1:0] idx_of(
      input logic [dsp_port_pkg::ADDR_W-1:0] a
   );
      idx_of = a[dsp_port_pkg::IDX_LSB +: dsp_port_pkg::IDX_W];
   endfunction : idx_of

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------

   logic [dsp_port_pkg::REG_W-1:0]     regs [NREGS];
   logic [dsp_port_pkg::NUM_SRST-1:0]  srst;
   logic                               wr_prev;
   logic                               rd_prev;
   logic                               wr_start;
   logic                               rd_start;
   logic                               dsp_sel;
   logic                               sys_sel;
   logic [dsp_port_pkg::IDX_W-1:0]     idx;
   logic [dsp_port_pkg::REG_W-1:0]     wbyte;

   // Shared decode of the current bus cycle.
   assign idx     = idx_of(PORT.addr);
   assign dsp_sel = ~PORT.cs_b;
   assign sys_sel = ~PORT.sys_cs_b & (idx == dsp_port_pkg::SRST_IDX);

   // Only the low byte of the low half-word carries data.
   assign wbyte = PORT.data[dsp_port_pkg::REG_W-1:0];

   // -------------------------------------------------------------
   // Strobe edge detection
   // -------------------------------------------------------------

   // Previous strobe levels; idle high after reset.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         wr_prev <= 1'b1;
         rd_prev <= 1'b1;
      end
      else
      begin
         wr_prev <= PORT.wr_b;
         rd_prev <= PORT.rd_b;
      end
   end

   // A strobe's first low cycle starts the access.
   assign wr_start = ~PORT.wr_b & wr_prev;
   assign rd_start = ~PORT.rd_b & rd_prev;

   // -------------------------------------------------------------
   // DSP register file
   // -------------------------------------------------------------

   // Host writes land on the first strobe cycle; a core
   // update to the same register in that cycle wins.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         for (int i = 0; i < NREGS; i++)
            regs[i] <= '0;
      end
      else
      begin
         if (wr_start && dsp_sel)
            regs[idx] <= wbyte;
         if (CORE_WE_I)
            regs[CORE_IDX_I] <= CORE_DATA_I;
      end
   end

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------

   // Data is driven one edge into the strobe and held while
   // the strobe stays low, well inside one 100 ns cycle.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         PORT.dev_d    <= '0;
         PORT.dev_d_oe <= 1'b0;
      end
      else if (~PORT.rd_b && dsp_sel)
      begin
         PORT.dev_d <= {{(dsp_port_pkg::BUS_W -
                         dsp_port_pkg::REG_W){1'b0}}, regs[idx]};
         PORT.dev_d_oe <= 1'b1;
      end
      else if (~PORT.rd_b && sys_sel)
      begin
         PORT.dev_d <= {{(dsp_port_pkg::BUS_W -
                         dsp_port_pkg::NUM_SRST){1'b0}}, srst};
         PORT.dev_d_oe <= 1'b1;
      end
      else
      begin
         PORT.dev_d    <= '0;
         PORT.dev_d_oe <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Host access notices to the DSP core
   // -------------------------------------------------------------

   // One-cycle pulses with the index of the access, and the byte of a write.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         HOST_WR_O   <= 1'b0;
         HOST_RD_O   <= 1'b0;
         HOST_IDX_O  <= '0;
         HOST_DATA_O <= '0;
      end
      else
      begin
         HOST_WR_O <= wr_start & dsp_sel;
         HOST_RD_O <= rd_start & dsp_sel;
         if ((wr_start | rd_start) & dsp_sel)
            HOST_IDX_O <= idx;
         if (wr_start & dsp_sel)
            HOST_DATA_O <= wbyte;
      end
   end

   // -------------------------------------------------------------
   // Interrupt line
   // -------------------------------------------------------------

   // The core request reaches the host on its own line.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         PORT.irq <= 1'b0;
      else
         PORT.irq <= CORE_IRQ_I;
   end

   // -------------------------------------------------------------
   // Soft reset register
   // -------------------------------------------------------------

   // Cleared by system reset, so every subsystem is held
   // until software writes ones to the bits it needs.
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         srst <= dsp_port_pkg::SRST_INIT;
      else if (wr_start && sys_sel)
         srst <= wbyte[dsp_port_pkg::NUM_SRST-1:0];
   end

   // Bit at one lets the subsystem run.
   assign DSP_CODEC_RST_B_O = srst[dsp_port_pkg::DSP_BIT];
   assign VOUT_RST_B_O      = srst[dsp_port_pkg::VOUT_BIT];
   assign VIN_RST_B_O       = srst[dsp_port_pkg::VIN_BIT];
   assign FIFO_RST_B_O      = srst[dsp_port_pkg::FIFO_BIT];

endmodule : dsp_port_dev

`default_nettype wire

// >>> dv/dsp_port_chk.sv
// Purpose: Assertions on the bus joining host end and device end.
// Assumes: One clock, reset low active.
// Notes:   Sees only the interface signals.

`timescale 1ns/1ps
`default_nettype none

module dsp_port_chk (
   // Clock and reset.
   input wire logic                             CORE_CLK_I,
   input wire logic                             RST_B_I,
   // Bus signals.
   input wire logic                             cs_b,
   input wire logic                             sys_cs_b,
   input wire logic                             rd_b,
   input wire logic                             wr_b,
   input wire logic [dsp_port_pkg::ADDR_W-1:0]  addr,
   input wire logic [dsp_port_pkg::BUS_W-1:0]   host_d,
   input wire logic                             host_d_oe,
   input wire logic [dsp_port_pkg::BUS_W-1:0]   dev_d,
   input wire logic                             dev_d_oe
);

   // -------------------------------------------------------------
   // Bus timing and framing
   // -------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_B_I);

   // Strobes last two cycles, then two idle cycles follow.
   strobe_width_a: assert property ($fell(wr_b) || $fell(rd_b) |=>
      !(wr_b && rd_b) ##1 (wr_b && rd_b)) else $error("strobe width");
   recovery_gap_a: assert property ($rose(wr_b) || $rose(rd_b) |->
      (wr_b && rd_b) ##1 (wr_b && rd_b)) else $error("recovery short");
   one_bank_a: assert property (!(!cs_b && !sys_cs_b))
      else $error("both banks selected");
   strobe_bank_a: assert property (!(rd_b && wr_b) |-> cs_b ^ sys_cs_b)
      else $error("strobe without one bank");
   low_half_a: assert property (host_d_oe |->
      host_d[15:8] == 8'h00 && addr[0] == 1'b0) else $error("high byte");
   write_hold_a: assert property (!wr_b && !$past(wr_b) |->
      $stable(addr) && $stable(host_d) && host_d_oe) else $error("wr moved");
   read_drive_a: assert property ($fell(rd_b) && !cs_b |=>
      dev_d_oe && dev_d[15:8] == 8'h00) else $error("no read data");
   read_release_a: assert property ($rose(rd_b) |=> !dev_d_oe)
      else $error("bus held after read");
   no_fight_a: assert property (!(dev_d_oe && host_d_oe))
      else $error("both ends drive");

   // Main transfers seen.
   cover property (!wr_b && !cs_b);
   cover property (!rd_b && !cs_b);
   cover property (!wr_b && !sys_cs_b);

endmodule : dsp_port_chk

`default_nettype wire

// >>> dv/dsp_host_port_bridge_bench.sv
// Purpose: Self-checking bench for the DSP host port bridge.
// Assumes: Both ends joined by one interface instance.
// Notes:   Avalon master tasks drive the host end.

`timescale 1ns/1ps
`default_nettype none

module dsp_host_port_bridge_bench;

   logic                            clk = 1'b0;
   logic                            rst_b = 1'b0;
   logic [dsp_port_pkg::AV_W-1:0]   av_a = '0;
   logic                            av_r = 1'b0;
   logic                            av_w = 1'b0;
   logic [31:0]                     av_d = 32'h0000_0000;
   logic [31:0]                     rdata;
   logic                            wreq;
   logic                            irq_o;
   logic                            core_we = 1'b0;
   logic                            core_irq = 1'b0;
   logic [3:0]                      core_idx = 4'h0;
   logic [7:0]                      core_d = 8'h00;
   logic                            h_wr;
   logic                            h_rd;
   int                              rd_n = 0;
   logic [3:0]                      h_idx;
   logic [3:0]                      w_idx;
   logic [7:0]                      h_dat;
   logic [7:0]                      w_dat;
   logic [3:0]                      srst;
   logic [31:0]                     q;
   int                              failures = 0;
   int                              cmp_count = 0;

   // Clock of 40 ns period.
   always #20 clk = ~clk;

   dsp_port_if dsp_port_if_i ();

   dsp_host_ctrl dsp_host_ctrl_i (.CORE_CLK_I(clk), .RST_B_I(rst_b),
      .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_r), .AVS_WRITE_I(av_w),
      .AVS_WRITEDATA_I(av_d), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wreq), .IRQ_O(irq_o), .PORT(dsp_port_if_i));

   dsp_port_dev dsp_port_dev_i (.CORE_CLK_I(clk), .RST_B_I(rst_b),
      .PORT(dsp_port_if_i), .CORE_WE_I(core_we), .CORE_IDX_I(core_idx),
      .CORE_DATA_I(core_d), .CORE_IRQ_I(core_irq), .HOST_WR_O(h_wr),
      .HOST_RD_O(h_rd), .HOST_IDX_O(h_idx), .HOST_DATA_O(h_dat),
      .DSP_CODEC_RST_B_O(srst[3]), .VIN_RST_B_O(srst[2]),
      .FIFO_RST_B_O(srst[1]), .VOUT_RST_B_O(srst[0]));

   dsp_port_chk dsp_port_chk_i (.CORE_CLK_I(clk), .RST_B_I(rst_b),
      .cs_b(dsp_port_if_i.cs_b), .sys_cs_b(dsp_port_if_i.sys_cs_b),
      .rd_b(dsp_port_if_i.rd_b), .wr_b(dsp_port_if_i.wr_b),
      .addr(dsp_port_if_i.addr), .host_d(dsp_port_if_i.host_d),
      .host_d_oe(dsp_port_if_i.host_d_oe), .dev_d(dsp_port_if_i.dev_d),
      .dev_d_oe(dsp_port_if_i.dev_d_oe));

   // Keeps index and data of the last host write notice, and
   // counts the read notices.
   always @(posedge clk)
   begin
      if (h_wr === 1'b1)
      begin
         w_idx <= h_idx;
         w_dat <= h_dat;
      end
      if (h_rd === 1'b1)
         rd_n <= rd_n + 1;
   end

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] s);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // One Avalon transfer, held until waitrequest is seen low.
   task automatic av(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
      @(posedge clk);
      av_w <= w;
      av_r <= !w;
      av_a <= a;
      av_d <= {24'h00_0000, d};
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      av_w <= 1'b0;
      av_r <= 1'b0;
   endtask : av

   // Starts a port cycle and polls until it is over.
   task automatic go(input logic [7:0] c);
      av(1'b1, dsp_port_pkg::A_CTRL, c);
      do av(1'b0, dsp_port_pkg::A_STATUS, 8'h00); while (q[0] !== 1'b0);
   endtask : go

   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end

   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("soft resets", 8'h00, {4'h0, srst});
      av(1'b1, dsp_port_pkg::A_WDATA, 8'h0f);
      go(8'h05);
      chk("soft resets", 8'h0f, {4'h0, srst});
      av(1'b1, dsp_port_pkg::A_WDATA, 8'h07);
      go(8'h05);
      chk("soft resets", 8'h07, {4'h0, srst});
      go(8'h07);
      av(1'b0, dsp_port_pkg::A_RDATA, 8'h00);
      chk("soft reset read", 8'h07, q[7:0]);
      for (int i = 0; i < 16; i++)
      begin
         av(1'b1, dsp_port_pkg::A_WDATA, 8'(8'ha0 + i));
         go({4'(i), 4'h1});
         chk("write index", 8'(i), {4'h0, w_idx});
         chk("write data", 8'(8'ha0 + i), w_dat);
         go({4'(i), 4'h3});
         av(1'b0, dsp_port_pkg::A_RDATA, 8'h00);
         chk("read data", 8'(8'ha0 + i), q[7:0]);
      end
      chk("read notices", 8'h10, 8'(rd_n));
      @(posedge clk);
      core_we <= 1'b1;
      core_idx <= 4'h9;
      core_d <= 8'h3c;
      @(posedge clk);
      core_we <= 1'b0;
      go(8'h93);
      av(1'b0, dsp_port_pkg::A_RDATA, 8'h00);
      chk("core data", 8'h3c, q[7:0]);
      av(1'b0, dsp_port_pkg::A_IRQ_STAT, 8'h00);
      chk("irq status", 8'h02, q[7:0]);
      av(1'b1, dsp_port_pkg::A_IRQ_CLR, 8'h03);
      core_irq <= 1'b1;
      repeat (3) @(posedge clk);
      chk("irq line", 8'h01, {7'h00, dsp_port_if_i.irq});
      chk("masked irq", 8'h00, {7'h00, irq_o});
      av(1'b1, dsp_port_pkg::A_IRQ_EN, 8'h01);
      @(posedge clk);
      chk("irq out", 8'h01, {7'h00, irq_o});
      av(1'b1, dsp_port_pkg::A_IRQ_CLR, 8'h01);
      @(posedge clk);
      chk("cleared irq", 8'h00, {7'h00, irq_o});
      av(1'b0, 3'h7, 8'h00);
      chk("unmapped", 8'h00, q[7:0]);
      finish_test();
   end

endmodule : dsp_host_port_bridge_bench

`default_nettype wire
